// >>> common/dic_pkg.sv
/*
  Constants, states and carrier types for the drive input command decoder.
  Assumes one 200 MHz clock and terminal assignment codes held static by the configuring party.
*/
package dic_pkg;

  localparam int unsigned NUM_TERM   = 7;
  localparam int unsigned CODE_W     = 11;
  localparam int unsigned SYNC_DEPTH = 3;

  // Assignment codes, normal logic
  localparam logic [CODE_W-1:0] CODE_PRESET_BIT0 = 11'h000;
  localparam logic [CODE_W-1:0] CODE_PRESET_BIT1 = 11'h001;
  localparam logic [CODE_W-1:0] CODE_PRESET_BIT2 = 11'h002;
  localparam logic [CODE_W-1:0] CODE_HOLD        = 11'h006;
  localparam logic [CODE_W-1:0] CODE_COAST       = 11'h007;
  localparam logic [CODE_W-1:0] CODE_ALARM_RESET = 11'h008;
  localparam logic [CODE_W-1:0] CODE_TRIP        = 11'h009;
  localparam logic [CODE_W-1:0] CODE_FREQ_SRC    = 11'h00B;
  localparam logic [CODE_W-1:0] CODE_DC_BRAKE    = 11'h00D;
  localparam logic [CODE_W-1:0] CODE_LINE_FIFTY  = 11'h00F;
  localparam logic [CODE_W-1:0] CODE_LINE_SIXTY  = 11'h010;
  localparam logic [CODE_W-1:0] CODE_RUN_FWD     = 11'h062;
  localparam logic [CODE_W-1:0] CODE_RUN_BWD     = 11'h063;
  // Added to a code to make the command active while the terminal is off
  localparam logic [CODE_W-1:0] CODE_INVERT_OFS  = 11'h3E8;

  localparam logic [2:0] PRESET_NONE = 3'h0;

  typedef enum logic [1:0] {
    DIC_LINE_IDLE  = 2'b00,
    DIC_LINE_RUN   = 2'b01,
    DIC_LINE_BLOCK = 2'b10
  } dic_line_e;

  typedef logic [NUM_TERM-1:0][CODE_W-1:0] dic_codes_t;

  typedef struct packed {
    logic [2:0] preset_index;
    logic       freq_source_two;
    logic       run_forward;
    logic       run_backward;
    logic       drive_enable;
    logic       alarm_relay_out;
    logic       alarm_display;
    logic       alarm_hold;
    logic       dc_brake_request;
    logic       line_switch_fifty;
    logic       line_switch_sixty;
    logic       ordinary_start;
  } dic_cmd_s;

  localparam dic_cmd_s CMD_RESET = '0;

endpackage : dic_pkg

// >>> src/dic_sync.sv
/*
  Three-stage terminal synchroniser; a level is taken once stages two and three agree.
  Assumes asynchronous, possibly bouncing terminal levels.
*/
module dic_sync #(
  parameter int unsigned WIDTH = 7
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_comb
      begin
        nxt_out[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : out_ff[gi];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff  <= level_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign level_out = out_ff;

endmodule : dic_sync

// >>> src/dic_decoder.sv
/*
  Drive input command decoder: turns programmable terminal levels into run, preset,
  alarm, brake and line switch-over commands.
  Assumes static assignment codes and an outside controller driving the terminals.
*/
module dic_decoder (
  input  wire logic                        ref_clk,
  input  wire logic                        rstn,
  input  wire logic [dic_pkg::NUM_TERM-1:0] term_level,
  input  wire dic_pkg::dic_codes_t          term_code,
  output dic_pkg::dic_cmd_s                 cmd_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic cmd_on(input logic [dic_pkg::NUM_TERM-1:0] lvl,
                                  input dic_pkg::dic_codes_t codes,
                                  input logic [dic_pkg::CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < dic_pkg::NUM_TERM; i++)
      hit = hit | (codes[i] == code && lvl[i]) | (codes[i] == code + dic_pkg::CODE_INVERT_OFS && !lvl[i]);
    return hit;
  endfunction : cmd_on

  function automatic logic cmd_assigned(input dic_pkg::dic_codes_t codes,
                                        input logic [dic_pkg::CODE_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < dic_pkg::NUM_TERM; i++)
      hit = hit | (codes[i] == code) | (codes[i] == code + dic_pkg::CODE_INVERT_OFS);
    return hit;
  endfunction : cmd_assigned

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronised terminals
  logic [dic_pkg::NUM_TERM-1:0] lvl;
  dic_sync #(
    .WIDTH (dic_pkg::NUM_TERM)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .level_in  (term_level),
    .level_out (lvl)
  );

  logic                         fwd_on, bwd_on, hold_on, hold_used, coast_on, rst_on;
  logic                         trip_ok, trip_used, dcb_on, line_switch_fifty_on, line_switch_sixty_on, trip_now;
  logic [dic_pkg::SYNC_DEPTH:0] warm_ff, nxt_warm;

  always_comb
  begin
    fwd_on    = cmd_on(lvl, term_code, dic_pkg::CODE_RUN_FWD);
    bwd_on    = cmd_on(lvl, term_code, dic_pkg::CODE_RUN_BWD);
    hold_on   = cmd_on(lvl, term_code, dic_pkg::CODE_HOLD);
    hold_used = cmd_assigned(term_code, dic_pkg::CODE_HOLD);
    coast_on  = cmd_on(lvl, term_code, dic_pkg::CODE_COAST);
    rst_on    = cmd_on(lvl, term_code, dic_pkg::CODE_ALARM_RESET);
    trip_ok   = cmd_on(lvl, term_code, dic_pkg::CODE_TRIP);
    trip_used = cmd_assigned(term_code, dic_pkg::CODE_TRIP);
    dcb_on    = cmd_on(lvl, term_code, dic_pkg::CODE_DC_BRAKE);
    line_switch_fifty_on   = cmd_on(lvl, term_code, dic_pkg::CODE_LINE_FIFTY);
    line_switch_sixty_on   = cmd_on(lvl, term_code, dic_pkg::CODE_LINE_SIXTY);
    // Fail-safe: an unpowered trip terminal means trip
    // Synchroniser reads zero until primed, which would fake a trip after reset
    trip_now  = trip_used && !trip_ok && warm_ff[dic_pkg::SYNC_DEPTH];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Edge history, three-wire latch, alarms
  logic       fwd_d_ff, bwd_d_ff, rst_d_ff, relay_ff, hold_alm_ff;
  logic [1:0] latch_ff, nxt_latch;
  logic       nxt_relay, nxt_hold_alm, rst_rise, rst_fall, run_f, run_b;

  always_comb
  begin
    rst_rise  = rst_on && !rst_d_ff;
    rst_fall  = !rst_on && rst_d_ff;
    nxt_warm  = {warm_ff[dic_pkg::SYNC_DEPTH-1:0], 1'b1};
    nxt_latch = latch_ff;
    if (!hold_on)
      nxt_latch = 2'h0;
    else if (latch_ff == 2'h0 && fwd_on && !fwd_d_ff)
      nxt_latch = 2'h1;
    else if (latch_ff == 2'h0 && bwd_on && !bwd_d_ff)
      nxt_latch = 2'h2;
    if (hold_used)
    begin
      run_f = latch_ff[0];
      run_b = latch_ff[1];
    end
    else
    begin
      // Both levels on is ambiguous, so the drive stops
      run_f = fwd_on && !bwd_on;
      run_b = bwd_on && !fwd_on;
    end
    // A trip in the same cycle as a reset edge wins
    nxt_relay    = trip_now ? 1'b1 : (rst_rise ? 1'b0 : relay_ff);
    nxt_hold_alm = trip_now ? 1'b1 : (rst_fall ? 1'b0 : hold_alm_ff);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fwd_d_ff    <= 1'b0;
      bwd_d_ff    <= 1'b0;
      rst_d_ff    <= 1'b0;
      latch_ff    <= 2'h0;
      relay_ff    <= 1'b0;
      hold_alm_ff <= 1'b0;
      warm_ff     <= '0;
    end
    else
    begin
      fwd_d_ff    <= fwd_on;
      bwd_d_ff    <= bwd_on;
      rst_d_ff    <= rst_on;
      latch_ff    <= nxt_latch;
      relay_ff    <= nxt_relay;
      hold_alm_ff <= nxt_hold_alm;
      warm_ff     <= nxt_warm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line switch-over
  dic_pkg::dic_line_e line_ff, nxt_line;
  logic               sixty_ff, nxt_sixty, run_any, run_d_ff, sw_on, blocked;

  always_comb
  begin
    run_any   = run_f || run_b;
    sw_on     = line_switch_fifty_on || line_switch_sixty_on;
    blocked   = hold_alm_ff || coast_on || trip_now;
    nxt_line  = line_ff;
    nxt_sixty = sixty_ff;
    unique case (line_ff)
      dic_pkg::DIC_LINE_IDLE:
      begin
        if (sw_on && run_any && !run_d_ff)
        begin
          nxt_line  = blocked ? dic_pkg::DIC_LINE_BLOCK : dic_pkg::DIC_LINE_RUN;
          nxt_sixty = line_switch_sixty_on;
        end
      end
      dic_pkg::DIC_LINE_RUN:
      begin
        if (!run_any)
          nxt_line = dic_pkg::DIC_LINE_IDLE;
        else if (blocked)
          nxt_line = dic_pkg::DIC_LINE_BLOCK;
      end
      dic_pkg::DIC_LINE_BLOCK:
      begin
        if (!run_any)
          nxt_line = dic_pkg::DIC_LINE_IDLE;
      end
      default:
        nxt_line = dic_pkg::DIC_LINE_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_ff  <= dic_pkg::DIC_LINE_IDLE;
      sixty_ff <= 1'b0;
      run_d_ff <= 1'b0;
    end
    else
    begin
      line_ff  <= nxt_line;
      sixty_ff <= nxt_sixty;
      run_d_ff <= run_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output register
  dic_pkg::dic_cmd_s out_ff;
  dic_pkg::dic_cmd_s nxt_out;
  logic              in_line;

  always_comb
  begin
    in_line                   = (line_ff == dic_pkg::DIC_LINE_RUN);
    nxt_out                   = dic_pkg::CMD_RESET;
    nxt_out.preset_index[0]   = cmd_on(lvl, term_code, dic_pkg::CODE_PRESET_BIT0);
    nxt_out.preset_index[1]   = cmd_on(lvl, term_code, dic_pkg::CODE_PRESET_BIT1);
    nxt_out.preset_index[2]   = cmd_on(lvl, term_code, dic_pkg::CODE_PRESET_BIT2);
    nxt_out.freq_source_two   = cmd_on(lvl, term_code, dic_pkg::CODE_FREQ_SRC);
    nxt_out.run_forward       = run_f;
    nxt_out.run_backward      = run_b;
    nxt_out.drive_enable      = run_any && !blocked;
    nxt_out.alarm_relay_out   = nxt_relay;
    nxt_out.alarm_display     = nxt_hold_alm;
    nxt_out.alarm_hold        = nxt_hold_alm;
    nxt_out.dc_brake_request  = dcb_on;
    nxt_out.line_switch_fifty = in_line && !sixty_ff && !blocked;
    nxt_out.line_switch_sixty = in_line && sixty_ff && !blocked;
    nxt_out.ordinary_start    = run_any && !blocked && !in_line;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      out_ff <= dic_pkg::CMD_RESET;
    else
      out_ff <= nxt_out;
  end

  assign cmd_out = out_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_trip_seen;
    trip_now;
  endsequence
  sequence s_alarm_shown;
    out_ff.alarm_relay_out && out_ff.alarm_hold && !out_ff.drive_enable;
  endsequence

  property p_preset;
    cmd_out.preset_index == $past(nxt_out.preset_index);
  endproperty
  a_preset: assert property (p_preset) else $error("preset index not registered");
  property p_latch_release;
    !hold_on |=> latch_ff == 2'h0;
  endproperty
  a_latch_release: assert property (p_latch_release) else $error("three-wire latch kept");
  property p_latch_keep;
    hold_on && latch_ff != 2'h0 && hold_used |=> $stable(latch_ff) || !hold_on;
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("three-wire latch changed");
  property p_two_wire;
    !hold_used && fwd_on && !bwd_on |=> out_ff.run_forward;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire run lost");
  property p_coast;
    coast_on |=> !out_ff.drive_enable && !out_ff.alarm_relay_out || $past(relay_ff || trip_now);
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop not honoured");
  property p_trip;
    s_trip_seen |=> s_alarm_shown;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not shown");
  property p_trip_latched;
    hold_alm_ff && !rst_fall && !trip_now |=> hold_alm_ff;
  endproperty
  a_trip_latched: assert property (p_trip_latched) else $error("alarm hold lost without reset");
  property p_reset_relay;
    rst_rise && !trip_now |=> !relay_ff;
  endproperty
  a_reset_relay: assert property (p_reset_relay) else $error("relay not cleared by reset");
  property p_source;
    !cmd_assigned(term_code, dic_pkg::CODE_FREQ_SRC) |=> !out_ff.freq_source_two;
  endproperty
  a_source: assert property (p_source) else $error("source two without assignment");
  property p_brake;
    dcb_on |=> out_ff.dc_brake_request;
  endproperty
  a_brake: assert property (p_brake) else $error("DC brake missing");
  property p_line_block;
    line_ff == dic_pkg::DIC_LINE_IDLE && sw_on && run_any && !run_d_ff && blocked
      |=> line_ff == dic_pkg::DIC_LINE_BLOCK ##1 !out_ff.line_switch_fifty && !out_ff.line_switch_sixty;
  endproperty
  a_line_block: assert property (p_line_block) else $error("line start despite alarm or coast");

endmodule : dic_decoder

// >>> test/dic_relay_seq.sv
/*
  Model of the outside relay sequence that drives the terminal levels.
  Assumes the bench calls its tasks and that levels change just after a falling edge.
*/
module dic_relay_seq #(
  parameter int unsigned RST_HOLD_CYC = 40,
  parameter int unsigned LEAD_CYC     = 40,
  parameter int unsigned OVERLAP_CYC  = 80,
  parameter int unsigned RESTART_MODE = 0
) (
  input  wire logic                         ref_clk,
  output logic      [dic_pkg::NUM_TERM-1:0] term_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // Hold times shortened from the real spans to keep the run short
  initial term_level = '0;

  task automatic set_term(input int idx, input logic val);
    @(negedge ref_clk);
    term_level[idx] = val;
  endtask : set_term

  // Reset stays on for the whole minimum span, never a short glitch
  task automatic hold_reset(input int idx);
    set_term(idx, 1'b1);
    repeat (RST_HOLD_CYC) @(negedge ref_clk);
  endtask : hold_reset

  // Switch-over leads run, then both overlap; only one line command is ever assigned
  task automatic line_start(input int sw_idx, input int run_idx, input int coast_idx);
    set_term(sw_idx, 1'b1);
    if (RESTART_MODE >= 3 && RESTART_MODE <= 5)
    begin
      set_term(coast_idx, 1'b1);
    end
    repeat (LEAD_CYC) @(negedge ref_clk);
    set_term(run_idx, 1'b1);
    repeat (OVERLAP_CYC) @(negedge ref_clk);
  endtask : line_start

  task automatic line_stop(input int sw_idx, input int run_idx);
    set_term(run_idx, 1'b0);
    set_term(sw_idx, 1'b0);
  endtask : line_stop
endmodule : dic_relay_seq

// >>> test/drive_input_command_decoder_bench.sv
/*
  Self-checking bench for the terminal command decoder.
  Assumes the relay sequence model drives all terminals and codes are changed only when idle.
*/
module drive_input_command_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [10:0] NONE = 11'h7FF;

  logic                ref_clk;
  logic                rstn;
  logic [6:0]          term_level;
  dic_pkg::dic_codes_t term_code;
  dic_pkg::dic_cmd_s   cmd;
  int                  num_errors;
  int                  total_checks;

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  dic_decoder dut (.ref_clk(ref_clk), .rstn(rstn), .term_level(term_level), .term_code(term_code), .cmd_out(cmd));
  dic_relay_seq u_seq (.ref_clk(ref_clk), .term_level(term_level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [2:0] seen, input logic [2:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic check_bit(input string name, input logic seen, input logic exp);
    check(name, {2'h0, seen}, {2'h0, exp});
  endtask : check_bit

  // Five edges of latency, six via the latch or line state; eight leaves margin
  task automatic settle();
    repeat (8) @(negedge ref_clk);
  endtask : settle

  task automatic set_codes(input logic [6:0] lv, input logic [10:0] c0, c1, c2, c3, c4);
    @(negedge ref_clk);
    u_seq.term_level = lv;
    term_code = {NONE, NONE, c4, c3, c2, c1, c0};
    settle();
  endtask : set_codes

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_preset();
    int i;
    set_codes(7'h00, dic_pkg::CODE_PRESET_BIT0, dic_pkg::CODE_PRESET_BIT1, dic_pkg::CODE_PRESET_BIT2, NONE, NONE);
    for (i = 0; i < 8; i++)
    begin
      u_seq.set_term(0, i[0]);
      u_seq.set_term(1, i[1]);
      u_seq.set_term(2, i[2]);
      settle();
      check("preset_index", cmd.preset_index, i[2:0]);
    end
    check_bit("freq_source_two", cmd.freq_source_two, 1'b0);
    set_codes(7'h00, dic_pkg::CODE_PRESET_BIT0 + dic_pkg::CODE_INVERT_OFS, NONE, NONE, NONE, NONE);
    check("preset_index", cmd.preset_index, 3'h1);
    $display("test preset done");
  endtask : t_preset

  task automatic t_two_wire();
    set_codes(7'h00, dic_pkg::CODE_RUN_FWD, dic_pkg::CODE_RUN_BWD, dic_pkg::CODE_COAST, dic_pkg::CODE_DC_BRAKE,
              dic_pkg::CODE_FREQ_SRC);
    u_seq.set_term(3, 1'b1);
    settle();
    check_bit("dc_brake_request", cmd.dc_brake_request, 1'b1);
    check_bit("drive_enable", cmd.drive_enable, 1'b0);
    u_seq.set_term(0, 1'b1);
    settle();
    check_bit("run_forward", cmd.run_forward, 1'b1);
    check_bit("drive_enable", cmd.drive_enable, 1'b1);
    u_seq.set_term(2, 1'b1);
    settle();
    check_bit("drive_enable", cmd.drive_enable, 1'b0);
    check_bit("alarm_relay_out", cmd.alarm_relay_out, 1'b0);
    u_seq.set_term(2, 1'b0);
    u_seq.set_term(0, 1'b0);
    u_seq.set_term(1, 1'b1);
    settle();
    check_bit("run_forward", cmd.run_forward, 1'b0);
    check_bit("run_backward", cmd.run_backward, 1'b1);
    u_seq.set_term(4, 1'b1);
    settle();
    check_bit("freq_source_two", cmd.freq_source_two, 1'b1);
    u_seq.set_term(4, 1'b0);
    settle();
    check_bit("freq_source_two", cmd.freq_source_two, 1'b0);
    $display("test two wire done");
  endtask : t_two_wire

  task automatic t_three_wire();
    set_codes(7'h00, dic_pkg::CODE_RUN_FWD, dic_pkg::CODE_RUN_BWD, dic_pkg::CODE_HOLD, NONE, NONE);
    u_seq.set_term(2, 1'b1);
    u_seq.set_term(0, 1'b1);
    settle();
    u_seq.set_term(0, 1'b0);
    settle();
    check_bit("run_forward", cmd.run_forward, 1'b1);
    u_seq.set_term(1, 1'b1);
    settle();
    check_bit("run_forward", cmd.run_forward, 1'b1);
    check_bit("run_backward", cmd.run_backward, 1'b0);
    u_seq.set_term(1, 1'b0);
    u_seq.set_term(2, 1'b0);
    settle();
    check_bit("run_forward", cmd.run_forward, 1'b0);
    $display("test three wire done");
  endtask : t_three_wire

  task automatic t_trip();
    set_codes(7'h02, dic_pkg::CODE_RUN_FWD, dic_pkg::CODE_TRIP, dic_pkg::CODE_ALARM_RESET, NONE, NONE);
    u_seq.set_term(0, 1'b1);
    u_seq.set_term(1, 1'b0);
    settle();
    check_bit("alarm_relay_out", cmd.alarm_relay_out, 1'b1);
    check_bit("alarm_display", cmd.alarm_display, 1'b1);
    check_bit("drive_enable", cmd.drive_enable, 1'b0);
    u_seq.set_term(1, 1'b1);
    settle();
    check_bit("alarm_hold", cmd.alarm_hold, 1'b1);
    u_seq.hold_reset(2);
    check_bit("alarm_relay_out", cmd.alarm_relay_out, 1'b0);
    check_bit("alarm_hold", cmd.alarm_hold, 1'b1);
    u_seq.set_term(2, 1'b0);
    settle();
    check_bit("alarm_hold", cmd.alarm_hold, 1'b0);
    check_bit("alarm_display", cmd.alarm_display, 1'b0);
    check_bit("drive_enable", cmd.drive_enable, 1'b1);
    $display("test trip done");
  endtask : t_trip

  task automatic t_line();
    int k;
    for (k = 0; k < 2; k++)
    begin
      set_codes(7'h00, dic_pkg::CODE_RUN_FWD, k ? dic_pkg::CODE_LINE_SIXTY : dic_pkg::CODE_LINE_FIFTY,
                dic_pkg::CODE_COAST, NONE, NONE);
      u_seq.line_start(1, 0, 2);
      check_bit("line_switch_fifty", cmd.line_switch_fifty, k == 0);
      check_bit("line_switch_sixty", cmd.line_switch_sixty, k == 1);
      check_bit("ordinary_start", cmd.ordinary_start, 1'b0);
      u_seq.line_stop(1, 0);
      settle();
    end
    u_seq.set_term(2, 1'b1);
    u_seq.line_start(1, 0, 2);
    check_bit("drive_enable", cmd.drive_enable, 1'b0);
    check_bit("line_switch_sixty", cmd.line_switch_sixty, 1'b0);
    u_seq.set_term(2, 1'b0);
    settle();
    check_bit("drive_enable", cmd.drive_enable, 1'b1);
    check_bit("ordinary_start", cmd.ordinary_start, 1'b1);
    check_bit("line_switch_sixty", cmd.line_switch_sixty, 1'b0);
    u_seq.line_stop(1, 0);
    $display("test line done");
  endtask : t_line

  // Healthy trip terminal through a mid-run reset: no alarm while the synchroniser fills
  task automatic t_power_up();
    set_codes(7'h02, NONE, dic_pkg::CODE_TRIP, NONE, NONE, NONE);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    settle();
    check_bit("alarm_hold", cmd.alarm_hold, 1'b0);
    check_bit("alarm_relay_out", cmd.alarm_relay_out, 1'b0);
    u_seq.set_term(1, 1'b0);
    settle();
    check_bit("alarm_hold", cmd.alarm_hold, 1'b1);
    $display("test power up done");
  endtask : t_power_up

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is about 750 cycles; this allows over twenty-five times that
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    num_errors = 0;
    total_checks = 0;
    rstn = 1'b0;
    term_code = {7{NONE}};
    repeat (6) @(negedge ref_clk);
    rstn = 1'b1;
    t_preset();
    t_two_wire();
    t_three_wire();
    t_trip();
    t_line();
    t_power_up();
    give_verdict();
  end
endmodule : drive_input_command_decoder_bench
